// ---- design/spgc_top.v ----
// Summary of operation
// - Sleep codes: idle, power-down, save, standby, extended
// - Idle stops only CPU and flash clocks
// - Comparator off in all non-idle sleep modes
// - Comparator using reference keeps reference on
// - Fuse-enabled brown-out detector stays on always
// - Reference on when detector or comparator needs
// - Reference off when detector off and comparator disabled or not on reference
// - Reference kept on in sleep: valid immediately
// - Enabled watchdog keeps running in sleep
// - Input buffers off when I/O clock halted
// - Wake-up pins keep input logic enabled
// - Debug enabled keeps main clock in sleep
// - Debug off by either fuse or disable bit
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "spgc_map.vh"
module spgc_top #(
   parameter NPINS = 35,
   parameter REF_START_CYCLES = (`SPGC_REF_START_NS + `SPGC_CLK_NS - 1) / `SPGC_CLK_NS
) (
   // Clock and reset
   input wire clock,
   input wire rstn,
   // Fuses, static pins
   input wire brownout_level_fuse,
   input wire debug_enable_fuse,
   input wire scan_port_enable_fuse,
   // Wake-up requirement per pin, from interrupt logic
   input wire [NPINS-1:0] wakePinMask,
   // External wake event, asynchronous
   input wire wakeEvent,
   // AXI4-Lite write address
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Gating outputs
   output reg cpuClkEn,
   output reg flashClkEn,
   output reg ioClkEn,
   output reg asyClkEn,
   output reg mainClkEn,
   output reg compEn,
   output reg refEn,
   output wire refReady,
   output reg bodEn,
   output reg wdogEn,
   output reg debugEn,
   output reg [NPINS-1:0] inBufEn
);
   // Reset release through two flip-flops
   reg rstMeta;
   reg rstSync;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   wire wakeSync;
   spgc_sync #(.WIDTH(1)) uWakeSync (
      .clock(clock),
      .rstn(rstSync),
      .din(wakeEvent),
      .dout(wakeSync)
   );

   // Fuses settle long before use; four flops still guard their release
   wire [2:0] fuseSync;
   spgc_sync #(.WIDTH(3)) uFuseSync (
      .clock(clock),
      .rstn(rstSync),
      .din({brownout_level_fuse, debug_enable_fuse, scan_port_enable_fuse}),
      .dout(fuseSync)
   );
   wire bodFuse = fuseSync[2];
   wire dbgFuse = fuseSync[1];
   wire scanFuse = fuseSync[0];

   // Software registers
   reg [2:0] sleepModeSel;
   reg scanPortDisable;
   reg acDisable;
   reg acUseRef;
   reg wdogEnable;
   reg asyncTimer;
   // Values latched at sleep entry
   reg [2:0] sleepMode;
   reg latAcDisable;
   reg latAcUseRef;
   reg latWdog;
   reg latAsync;
   reg latBod;
   reg latDebug;

   localparam ST_RUN = 3'b001;
   localparam ST_SLEEP = 3'b010;
   localparam ST_RESUME = 3'b100;
   reg [2:0] state;
   reg [2:0] next_state;

   // Bus handshake: address and data taken together
   wire wrTake = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   wire rdTake = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_awready = wrTake;
   assign s_axi_wready = wrTake;
   assign s_axi_arready = rdTake;

   wire [3:0] wa = {s_axi_awaddr[3:2], 2'h0};
   wire [3:0] ra = {s_axi_araddr[3:2], 2'h0};
   wire wrCtrl = wrTake && wa == `SPGC_A_CTRL && s_axi_wstrb[0];
   wire wrPer = wrTake && wa == `SPGC_A_PERIPH && s_axi_wstrb[0];
   wire wrCmd = wrTake && wa == `SPGC_A_CMD && s_axi_wstrb[0];
   wire sleepReq = wrCmd && s_axi_wdata[`SPGC_CMD_SLEEP] && state == ST_RUN;
   wire wakeReq = wakeSync || (wrCmd && s_axi_wdata[`SPGC_CMD_WAKE]);

   // Debug availability: every path may disable it
   wire debugAvail = dbgFuse && scanFuse && !scanPortDisable;

   always @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         sleepModeSel <= `SPGC_SM_IDLE;
         scanPortDisable <= 1'b0;
         acDisable <= 1'b0;
         acUseRef <= 1'b0;
         wdogEnable <= 1'b0;
         asyncTimer <= 1'b0;
      end else begin
         if (wrCtrl) begin
            sleepModeSel <= s_axi_wdata[`SPGC_CTRL_SM_HI:`SPGC_CTRL_SM_LO];
            scanPortDisable <= s_axi_wdata[`SPGC_CTRL_SCANDIS];
         end
         if (wrPer) begin
            acDisable <= s_axi_wdata[`SPGC_P_ACDIS];
            acUseRef <= s_axi_wdata[`SPGC_P_ACREF];
            wdogEnable <= s_axi_wdata[`SPGC_P_WDEN];
            asyncTimer <= s_axi_wdata[`SPGC_P_ASYNC];
         end
      end
   end

   // Sleep sequencing
   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (sleepReq) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wakeReq) begin
               next_state = ST_RESUME;
            end
         end
         ST_RESUME: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         state <= ST_RUN;
         sleepMode <= `SPGC_SM_IDLE;
         latAcDisable <= 1'b0;
         latAcUseRef <= 1'b0;
         latWdog <= 1'b0;
         latAsync <= 1'b0;
         latBod <= 1'b0;
         latDebug <= 1'b0;
      end else begin
         state <= next_state;
         if (sleepReq) begin
            sleepMode <= sleepModeSel;
            latAcDisable <= acDisable;
            latAcUseRef <= acUseRef;
            latWdog <= wdogEnable;
            latAsync <= asyncTimer;
            latBod <= bodFuse;
            latDebug <= debugAvail;
         end
      end
   end

   // Mode decode; reserved codes fall to the default and act as power-down
   wire asleep = state == ST_SLEEP;
   wire isIdle = sleepMode == `SPGC_SM_IDLE;
   reg slpIoClk;
   reg slpAsy;
   reg slpMainMode;
   always @* begin
      slpIoClk = 1'b0;
      slpAsy = 1'b0;
      slpMainMode = 1'b0;
      case (sleepMode)
         `SPGC_SM_IDLE: begin
            slpIoClk = 1'b1;
            slpAsy = 1'b1;
            slpMainMode = 1'b1;
         end
         `SPGC_SM_PDOWN: begin
            // All generated clocks halted except the main clock under debug
            slpAsy = 1'b0;
         end
         `SPGC_SM_PSAVE: begin
            slpAsy = latAsync;
         end
         `SPGC_SM_STBY: begin
            // Oscillator kept for a fast wake
            slpMainMode = 1'b1;
         end
         `SPGC_SM_XSTBY: begin
            slpAsy = latAsync;
            slpMainMode = 1'b1;
         end
         default: begin
            slpAsy = 1'b0;
         end
      endcase
   end
   wire slpMain = slpMainMode || latDebug;
   wire slpComp = isIdle && !latAcDisable;
   wire runComp = !acDisable;
   wire compNow = asleep ? slpComp : runComp;
   wire acRefNow = asleep ? (latAcUseRef && !latAcDisable) : (acUseRef && !acDisable);
   wire bodNow = asleep ? latBod : bodFuse;
   wire refNow = bodNow || acRefNow;
   // Reference held through sleep counts as ready on wake
   reg refHeld;

   always @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         cpuClkEn <= 1'b0;
         flashClkEn <= 1'b0;
         ioClkEn <= 1'b0;
         asyClkEn <= 1'b0;
         mainClkEn <= 1'b0;
         compEn <= 1'b0;
         refEn <= 1'b0;
         bodEn <= 1'b0;
         wdogEn <= 1'b0;
         debugEn <= 1'b0;
         inBufEn <= {NPINS{1'b0}};
         refHeld <= 1'b0;
      end else begin
         // CPU held off in resume until peripherals restored
         cpuClkEn <= state == ST_RUN;
         flashClkEn <= state == ST_RUN;
         ioClkEn <= asleep ? slpIoClk : 1'b1;
         asyClkEn <= asleep ? slpAsy : 1'b1;
         mainClkEn <= asleep ? slpMain : 1'b1;
         compEn <= compNow;
         refEn <= refNow;
         bodEn <= bodNow;
         wdogEn <= asleep ? latWdog : wdogEnable;
         debugEn <= debugAvail;
         if (asleep && !slpIoClk) begin
            inBufEn <= wakePinMask;
         end else begin
            inBufEn <= {NPINS{1'b1}};
         end
         if (asleep) begin
            refHeld <= refNow;
         end else if (state == ST_RUN) begin
            refHeld <= 1'b0;
         end
      end
   end

   spgc_ref_timer #(.START_CYCLES(REF_START_CYCLES)) uRefTimer (
      .clock(clock),
      .rstn(rstSync),
      .refOn(refEn),
      .keepReady(refHeld),
      .refReady(refReady)
   );

   wire [31:0] statWord = {20'h00000, asyClkEn, cpuClkEn, wdogEn, bodEn, debugEn,
      ioClkEn, mainClkEn, inBufEn[0], refReady, refEn, compEn, asleep};

   // Write response
   always @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SPGC_RESP_OKAY;
      end else if (wrTake) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wa == `SPGC_A_STAT) ? `SPGC_RESP_SLVERR : `SPGC_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read data
   always @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SPGC_RESP_OKAY;
      end else if (rdTake) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `SPGC_RESP_OKAY;
         case (ra)
            `SPGC_A_CTRL: s_axi_rdata <= {24'h000000, scanPortDisable, 4'h0, sleepModeSel};
            `SPGC_A_PERIPH: s_axi_rdata <= {28'h0000000, asyncTimer, wdogEnable,
               acUseRef, acDisable};
            `SPGC_A_CMD: s_axi_rdata <= 32'h00000000;
            `SPGC_A_STAT: s_axi_rdata <= statWord;
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `SPGC_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ---- design/spgc_map.vh ----
`ifndef SPGC_MAP_VH
`define SPGC_MAP_VH
// Sleep mode codes
`define SPGC_SM_IDLE 3'h0
`define SPGC_SM_PDOWN 3'h2
`define SPGC_SM_PSAVE 3'h3
`define SPGC_SM_STBY 3'h6
`define SPGC_SM_XSTBY 3'h7
// Register byte addresses
`define SPGC_A_CTRL 4'h0
`define SPGC_A_PERIPH 4'h4
`define SPGC_A_CMD 4'h8
`define SPGC_A_STAT 4'hC
// CTRL fields
`define SPGC_CTRL_SM_LO 0
`define SPGC_CTRL_SM_HI 2
`define SPGC_CTRL_SCANDIS 7
// PERIPH fields
`define SPGC_P_ACDIS 0
`define SPGC_P_ACREF 1
`define SPGC_P_WDEN 2
`define SPGC_P_ASYNC 3
// CMD fields
`define SPGC_CMD_SLEEP 0
`define SPGC_CMD_WAKE 1
// STAT fields
`define SPGC_S_ASLEEP 0
`define SPGC_S_ACON 1
`define SPGC_S_REFON 2
`define SPGC_S_REFRDY 3
`define SPGC_S_BUFON 4
`define SPGC_S_MAINCLK 5
`define SPGC_S_IOCLK 6
`define SPGC_S_DBGON 7
`define SPGC_S_BODON 8
`define SPGC_S_WDON 9
`define SPGC_S_CPUCLK 10
`define SPGC_S_ASYCLK 11
// Reference start-up time in ns
`define SPGC_REF_START_NS 70000
`define SPGC_CLK_NS 5
// AXI responses
`define SPGC_RESP_OKAY 2'h0
`define SPGC_RESP_SLVERR 2'h2
`endif

// ---- design/spgc_sync.v ----
`timescale 1ns/10ps
`include "spgc_map.vh"
module spgc_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input wire clock,
   input wire rstn,
   // Raw input and filtered output
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : gBit
         always @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               stage1[i] <= 1'b0;
               stage2[i] <= 1'b0;
               stage3[i] <= 1'b0;
               dout[i] <= 1'b0;
            end else begin
               stage1[i] <= din[i];
               stage2[i] <= stage1[i];
               stage3[i] <= stage2[i];
               // Change counts only when the last two stages agree
               if (stage2[i] == stage3[i]) begin
                  dout[i] <= stage3[i];
               end
            end
         end
      end
   endgenerate
endmodule

// ---- design/spgc_ref_timer.v ----
`timescale 1ns/10ps
`include "spgc_map.vh"
module spgc_ref_timer #(
   parameter START_CYCLES = 14000
) (
   // Clock and reset
   input wire clock,
   input wire rstn,
   // Reference enable and its ready flag
   input wire refOn,
   input wire keepReady,
   output reg refReady
);
   localparam CW = 24;
   reg [CW-1:0] count;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count <= {CW{1'b0}};
         refReady <= 1'b0;
      end else if (!refOn) begin
         count <= {CW{1'b0}};
         refReady <= 1'b0;
      end else if (keepReady) begin
         refReady <= 1'b1;
      end else if (!refReady) begin
         // Output unusable until start-up elapses
         if (count >= START_CYCLES[CW-1:0] - 24'h000001) begin
            refReady <= 1'b1;
         end else begin
            count <= count + 24'h000001;
         end
      end
   end
endmodule

// ---- testbench/spgc_top_assertions.sv ----
`timescale 1ns/10ps
module spgc_chk #(
   parameter NPINS = 35
) (
   // Clock and reset
   input wire clock,
   input wire rstn,
   // Static inputs
   input wire brownout_level_fuse,
   input wire debug_enable_fuse,
   input wire scan_port_enable_fuse,
   input wire [NPINS-1:0] wakePinMask,
   // Gating outputs
   input wire cpuClkEn,
   input wire ioClkEn,
   input wire mainClkEn,
   input wire compEn,
   input wire refEn,
   input wire refReady,
   input wire bodEn,
   input wire wdogEn,
   input wire debugEn,
   input wire [NPINS-1:0] inBufEn
);
   // Outputs lag the reset release by a few edges
   reg [3:0] up;
   wire ok;
   assign ok = up == 4'hF;
   always @(posedge clock or negedge rstn) begin
      if (!rstn)
         up <= 4'h0;
      else if (!ok)
         up <= up + 4'h1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_halt;
      ok && !ioClkEn && !$past(ioClkEn) && $stable(wakePinMask);
   endsequence
   sequence s_resume;
      ok && !cpuClkEn && $rose(ioClkEn);
   endsequence
   property p_bod; ok |-> bodEn == brownout_level_fuse; endproperty
   property p_ref; ok && bodEn |-> refEn; endproperty
   property p_comp; ok && !ioClkEn |-> !compEn; endproperty
   property p_buf; s_halt |-> inBufEn == wakePinMask; endproperty
   property p_dbgclk; ok && debugEn |-> mainClkEn; endproperty
   property p_dbgoff; ok && !(debug_enable_fuse && scan_port_enable_fuse) |-> !debugEn; endproperty
   property p_keep; ok && refEn && $past(refEn) && $past(refReady) |-> refReady; endproperty
   property p_wdog; ok && !cpuClkEn && !$past(cpuClkEn) |-> $stable(wdogEn); endproperty
   property p_wake; s_resume |-> &inBufEn ##[1:2] cpuClkEn; endproperty
   a_bod: assert property (p_bod) else $error("detector enable differs from fuse");
   a_ref: assert property (p_ref) else $error("reference off with detector on");
   a_comp: assert property (p_comp) else $error("comparator on in deep sleep");
   a_buf: assert property (p_buf) else $error("input buffers differ from wake mask");
   a_dbgclk: assert property (p_dbgclk) else $error("main clock stopped under debug");
   a_dbgoff: assert property (p_dbgoff) else $error("debug on with a fuse cleared");
   a_keep: assert property (p_keep) else $error("ready lost while reference on");
   a_wdog: assert property (p_wdog) else $error("watchdog changed in sleep");
   a_wake: assert property (p_wake) else $error("wake order wrong");
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin numErrors++; \
   $display("[ERR] %s expected %h seen %h", n, e, g); end end
bind spgc_top spgc_chk #(.NPINS(NPINS)) spgc_chk_i (.clock(clock), .rstn(rstn),
   .brownout_level_fuse(brownout_level_fuse), .debug_enable_fuse(debug_enable_fuse),
   .scan_port_enable_fuse(scan_port_enable_fuse), .wakePinMask(wakePinMask),
   .cpuClkEn(cpuClkEn), .ioClkEn(ioClkEn), .mainClkEn(mainClkEn), .compEn(compEn),
   .refEn(refEn), .refReady(refReady), .bodEn(bodEn), .wdogEn(wdogEn),
   .debugEn(debugEn), .inBufEn(inBufEn));
module testbench;
   reg clock = 1'b0;
   reg rstn = 1'b0;
   reg bodF = 1'b1;
   reg dbgF = 1'b1;
   reg scanF = 1'b1;
   reg [34:0] mask = 35'h0;
   reg wakeEv = 1'b0;
   reg [3:0] awaddr = 4'h0;
   reg [3:0] araddr = 4'h0;
   reg [31:0] wdata = 32'h0;
   reg awvalid = 1'b0;
   reg wvalid = 1'b0;
   reg bready = 1'b0;
   reg arvalid = 1'b0;
   reg rready = 1'b0;
   wire awr, wr, arr, bv, rv, cpuC, flC, ioC, asC, mnC, cmp, refE, refR, bodE, wdE, dbgE;
   wire [1:0] br, rr;
   wire [31:0] rd;
   wire [34:0] bufE;
   reg [1:0] resp;
   reg [31:0] rdat;
   reg [31:0] x = 32'h000150FD;
   reg [3:0] pv;
   reg [7:0] cv;
   reg [9:0] ev;
   integer numErrors = 0;
   integer testsRun = 0;
   integer p, i;
   always #2.5 clock = ~clock;
   spgc_top #(.NPINS(35), .REF_START_CYCLES(20)) spgc_top_i (.clock(clock), .rstn(rstn),
      .brownout_level_fuse(bodF), .debug_enable_fuse(dbgF), .scan_port_enable_fuse(scanF),
      .wakePinMask(mask), .wakeEvent(wakeEv), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready), .cpuClkEn(cpuC),
      .flashClkEn(flC), .ioClkEn(ioC), .asyClkEn(asC), .mainClkEn(mnC), .compEn(cmp),
      .refEn(refE), .refReady(refR), .bodEn(bodE), .wdogEn(wdE), .debugEn(dbgE),
      .inBufEn(bufE));
   function [31:0] nx(input [31:0] v);
      begin
         v = v ^ (v << 13);
         v = v ^ (v >> 17);
         nx = v ^ (v << 5);
      end
   endfunction
   // Sleep outputs: io, asy, main, comp, ref, cpu, flash, bod, wdog, debug
   function [9:0] gate(input [2:0] m, input as, input acd, input acr, input wde, input dj);
      reg id, dg;
      begin
         id = m == 3'h0;
         dg = dbgF & scanF & !dj;
         gate = {id, id | ((m == 3'h3 || m == 3'h7) & as), id | (m[2] & m[1]) | dg,
            id & !acd, bodF | (acr & !acd), 2'b00, bodF, wde, dg};
      end
   endfunction
   task axw(input [3:0] a, input [31:0] d);
      begin
         @(posedge clock);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         @(negedge clock);
         while (!(awr && wr))
            @(negedge clock);
         @(posedge clock);
         awvalid <= 1'b0;
         wvalid <= 1'b0;
         @(negedge clock);
         while (!bv)
            @(negedge clock);
         resp = br;
         @(posedge clock);
         bready <= 1'b0;
      end
   endtask
   task axr(input [3:0] a);
      begin
         @(posedge clock);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         @(negedge clock);
         while (!arr)
            @(negedge clock);
         @(posedge clock);
         arvalid <= 1'b0;
         @(negedge clock);
         while (!rv)
            @(negedge clock);
         rdat = rd;
         resp = rr;
         @(posedge clock);
         rready <= 1'b0;
      end
   endtask
   task endSim;
      begin
         $display("Checks run %0d, mismatches %0d", testsRun, numErrors);
         if (numErrors == 0 && testsRun > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      #200000;
      numErrors++;
      endSim;
   end
   initial begin
      for (p = 0; p < 2; p = p + 1) begin
         @(posedge clock);
         rstn <= 1'b0;
         bodF <= !p[0];
         scanF <= !p[0];
         repeat (16) @(posedge clock);
         rstn <= 1'b1;
         repeat (6) @(posedge clock);
         axw(4'hC, 32'h1);
         `CHK("status write", 2'h2, resp)
         axr(4'hC);
         `CHK("status running", 2'h2, {rdat[10], rdat[0]})
         for (i = 0; i < 16; i = i + 1) begin
            @(posedge clock);
            x = nx(x);
            pv = x[3:0];
            cv = {x[4], 4'h0, i[2:0]};
            mask <= {x[7:5], nx(x)};
            axw(4'h4, {28'h0, pv});
            axw(4'h0, {24'h0, cv});
            axr(4'h0);
            `CHK("control", cv, rdat[7:0])
            `CHK("read response", 2'h0, resp)
            // Let the reference start-up count finish first
            repeat (24) @(posedge clock);
            axw(4'h8, 32'h1);
            repeat (2) @(posedge clock);
            ev = gate(cv[2:0], pv[3], pv[0], pv[1], pv[2], cv[7]);
            `CHK("gating", ev, {ioC, asC, mnC, cmp, refE, cpuC, flC, bodE, wdE, dbgE})
            `CHK("buffers", (i[2:0] == 0) ? ~35'h0 : mask, bufE)
            axr(4'hC);
            `CHK("asleep", 1'b1, rdat[0])
            if (i[0])
               axw(4'h8, 32'h2);
            else begin
               wakeEv <= 1'b1;
               repeat (8) @(posedge clock);
               wakeEv <= 1'b0;
            end
            @(negedge clock);
            while (!cpuC)
               @(negedge clock);
            `CHK("restored", {1'b1, !pv[0], ~35'h0}, {ioC, cmp, bufE})
            if (ev[5])
               `CHK("reference ready", 1'b1, refR)
         end
      end
      endSim;
   end
endmodule
